// ---- design/xsfr_pkg.sv ----
// Constants shared by the xdata address extension and port SFR logic.
// Assumes an 8-bit SFR address space driven by the processor core.
`default_nettype none
package xsfr_pkg;
    localparam int ADDR_W = 24;
    localparam int NUM_PORTS = 9;
    // Port numbers served through SFRs, in bank order
    localparam logic [3:0] PORT_NUM [NUM_PORTS] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC, 4'hF};
    // Extension register offsets in SFR space
    localparam logic [7:0] OFS_PTR_A_LO = 8'h82;
    localparam logic [7:0] OFS_PTR_A_HI = 8'h83;
    localparam logic [7:0] OFS_PTR_B_LO = 8'h84;
    localparam logic [7:0] OFS_PTR_B_HI = 8'h85;
    localparam logic [7:0] OFS_PTR_SEL = 8'h86;
    localparam logic [7:0] OFS_PTR_A_UP = 8'h93;
    localparam logic [7:0] OFS_PTR_B_UP = 8'h95;
    localparam logic [7:0] OFS_IND_TOP = 8'hEA;
    localparam logic [7:0] OFS_IND_MID = 8'hA0;
    // Port k: fast data at base+3k, select at base+3k+1, pin state at base+3k+2
    localparam logic [7:0] OFS_PORT_BASE = 8'hC0;
    localparam logic [1:0] PORT_STRIDE = 2'd3;
    localparam logic [1:0] SUB_DATA = 2'd0;
    localparam logic [1:0] SUB_SEL = 2'd1;
    localparam logic [1:0] SUB_PIN = 2'd2;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_SEL = 8'h00;
    typedef enum logic [1:0] {PTR_HOLD, PTR_INC, PTR_LOAD} ptr_op_t;
endpackage : xsfr_pkg
`default_nettype wire

// ---- design/port_sfr_if.sv ----
// Register access path between the SFR decoder and the port bank.
// Assumes both ends share clk_sys_in.
`default_nettype none
interface port_sfr_if;
    logic ce;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport decoder (output ce, output wr, output addr, output wdata, input rdata, input hit);
    modport bank (input ce, input wr, input addr, input wdata, output rdata, output hit);
endinterface : port_sfr_if
`default_nettype wire

// ---- design/port_sfr_bank.sv ----
// Per-port fast output data, output source select and pin state registers.
// Assumes pins arrive asynchronously; hub data comes from the same clock.
`default_nettype none
module port_sfr_bank
    import xsfr_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    port_sfr_if.bank bus, // Register access
    input wire logic [8*PORTS-1:0] pin_in, // Raw pin levels
    input wire logic [8*PORTS-1:0] hub_data_in, // Hub output data
    output logic [8*PORTS-1:0] pin_out // Output buffer drive
);
    logic [PORTS-1:0] hit_vec;
    logic [7:0] rd_vec [PORTS];

    genvar k;
    generate
        for (k = 0; k < PORTS; k++) begin : g_port
            localparam logic [7:0] A_DATA = 8'(OFS_PORT_BASE + 8'(k * PORT_STRIDE) + SUB_DATA);
            localparam logic [7:0] A_SEL = 8'(OFS_PORT_BASE + 8'(k * PORT_STRIDE) + SUB_SEL);
            localparam logic [7:0] A_PIN = 8'(OFS_PORT_BASE + 8'(k * PORT_STRIDE) + SUB_PIN);
            logic [7:0] fast_data;
            logic [7:0] src_sel;
            logic [7:0] pin_meta;
            logic [7:0] pin_state;

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    fast_data <= RST_BYTE;
                end else if (bus.ce && bus.wr && bus.addr == A_DATA) begin
                    fast_data <= bus.wdata;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    src_sel <= RST_SEL;
                end else if (bus.ce && bus.wr && bus.addr == A_SEL) begin
                    src_sel <= bus.wdata;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta <= RST_BYTE;
                    pin_state <= RST_BYTE;
                end else if (bus.ce) begin
                    pin_meta <= pin_in[8*k +: 8];
                    pin_state <= pin_meta;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out[8*k +: 8] <= RST_BYTE;
                end else if (bus.ce) begin
                    pin_out[8*k +: 8] <= (src_sel & fast_data) | (~src_sel & hub_data_in[8*k +: 8]);
                end
            end

            always_comb begin
                hit_vec[k] = 1'b1;
                rd_vec[k] = RST_BYTE;
                if (bus.addr == A_DATA) begin
                    rd_vec[k] = fast_data;
                end else if (bus.addr == A_SEL) begin
                    rd_vec[k] = src_sel;
                end else if (bus.addr == A_PIN) begin
                    rd_vec[k] = pin_state;
                end else begin
                    hit_vec[k] = 1'b0;
                end
            end
        end
    endgenerate

    always_comb begin
        bus.rdata = RST_BYTE;
        for (int i = 0; i < PORTS; i++) begin
            bus.rdata = bus.rdata | rd_vec[i];
        end
    end

    assign bus.hit = |hit_vec;
endmodule : port_sfr_bank
`default_nettype wire

// ---- design/xdata_sfr.sv ----
// Data pointer select, xdata upper-address extension and port SFRs.
// Assumes the core presents one SFR access and one instruction event per
// enabled cycle on clk_sys_in, and pin levels arrive asynchronously.
`default_nettype none
module xdata_sfr
    import xsfr_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic clk_sys_in, // System clock, 25 MHz
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic ce_in, // Clock enable, freezes all state when low
    input wire logic sfr_wr_in, // SFR write strobe
    input wire logic sfr_rd_in, // SFR read strobe
    input wire logic [7:0] sfr_addr_in, // SFR address
    input wire logic [7:0] sfr_wdata_in, // SFR write data
    output logic [7:0] sfr_rdata_out, // SFR read data, one cycle after read
    output logic sfr_rvalid_out, // Read data valid pulse
    input wire ptr_op_t ptr_op_in, // Pointer increment or immediate load
    input wire logic [15:0] ptr_imm_in, // Immediate pointer value
    input wire logic external_data_move_in, // External-data move issued
    input wire logic external_data_move_indexed_in, // Move uses an index register
    input wire logic [7:0] index_val_in, // Value of the index register used
    output logic [15:0] active_ptr_out, // Selected pointer for reads and jumps
    output logic [ADDR_W-1:0] xaddr_out, // External-data address
    output logic xaddr_valid_out, // Address valid pulse
    input wire logic [8*PORTS-1:0] pin_in, // Port pin levels
    input wire logic [8*PORTS-1:0] hub_data_in, // Hub output data per pin
    output logic [8*PORTS-1:0] pin_out_out // Drive to pin output buffers
);
    logic rst_meta;
    logic rst_n;
    logic ptr_sel;
    logic [15:0] ptr [2];
    logic [7:0] ptr_up [2];
    logic [7:0] ind_top;
    logic [7:0] ind_mid;
    logic [7:0] next_rdata;
    logic wr_en;

    port_sfr_if pbus ();

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign wr_en = ce_in && sfr_wr_in;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ptr_sel <= 1'b0;
        end else if (wr_en && sfr_addr_in == OFS_PTR_SEL) begin
            ptr_sel <= sfr_wdata_in[0];
        end
    end

    // selected pointer takes inc and load
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ptr[0] <= {RST_BYTE, RST_BYTE};
            ptr[1] <= {RST_BYTE, RST_BYTE};
        end else if (ce_in) begin
            // Instruction ops win over a same-cycle SFR write to either pointer
            if (ptr_op_in == PTR_INC) begin
                ptr[ptr_sel] <= 16'(ptr[ptr_sel] + 16'h0001);
            end else if (ptr_op_in == PTR_LOAD) begin
                ptr[ptr_sel] <= ptr_imm_in;
            end else if (sfr_wr_in) begin
                if (sfr_addr_in == OFS_PTR_A_LO) begin
                    ptr[0][7:0] <= sfr_wdata_in;
                end else if (sfr_addr_in == OFS_PTR_A_HI) begin
                    ptr[0][15:8] <= sfr_wdata_in;
                end else if (sfr_addr_in == OFS_PTR_B_LO) begin
                    ptr[1][7:0] <= sfr_wdata_in;
                end else if (sfr_addr_in == OFS_PTR_B_HI) begin
                    ptr[1][15:8] <= sfr_wdata_in;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ptr_up[0] <= RST_BYTE;
            ptr_up[1] <= RST_BYTE;
            ind_top <= RST_BYTE;
            ind_mid <= RST_BYTE;
        end else if (wr_en) begin
            if (sfr_addr_in == OFS_PTR_A_UP) begin
                ptr_up[0] <= sfr_wdata_in;
            end else if (sfr_addr_in == OFS_PTR_B_UP) begin
                ptr_up[1] <= sfr_wdata_in;
            end else if (sfr_addr_in == OFS_IND_TOP) begin
                ind_top <= sfr_wdata_in;
            end else if (sfr_addr_in == OFS_IND_MID) begin
                ind_mid <= sfr_wdata_in;
            end
        end
    end

    // pointer for table reads and jumps
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            active_ptr_out <= {RST_BYTE, RST_BYTE};
        end else if (ce_in) begin
            active_ptr_out <= ptr[ptr_sel];
        end
    end

    // extensions reach the address only on a move
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            xaddr_out <= {RST_BYTE, RST_BYTE, RST_BYTE};
            xaddr_valid_out <= 1'b0;
        end else if (ce_in) begin
            xaddr_valid_out <= external_data_move_in;
            if (external_data_move_in) begin
                if (external_data_move_indexed_in) begin
                    // top and middle from indirect bytes
                    xaddr_out <= {ind_top, ind_mid, index_val_in};
                end else begin
                    xaddr_out <= {ptr_up[ptr_sel], ptr[ptr_sel]};
                end
            end
        end
    end

    assign pbus.ce = ce_in;
    assign pbus.wr = sfr_wr_in;
    assign pbus.addr = sfr_addr_in;
    assign pbus.wdata = sfr_wdata_in;

    port_sfr_bank #(
        .PORTS(PORTS)
    ) u_bank (
        .clk(clk_sys_in),
        .rst_n(rst_n),
        .bus(pbus),
        .pin_in(pin_in),
        .hub_data_in(hub_data_in),
        .pin_out(pin_out_out)
    );

    // Unmapped addresses read as zero
    always_comb begin
        next_rdata = RST_BYTE;
        if (sfr_addr_in == OFS_PTR_SEL) begin
            next_rdata = {7'h00, ptr_sel};
        end else if (sfr_addr_in == OFS_PTR_A_LO) begin
            next_rdata = ptr[0][7:0];
        end else if (sfr_addr_in == OFS_PTR_A_HI) begin
            next_rdata = ptr[0][15:8];
        end else if (sfr_addr_in == OFS_PTR_B_LO) begin
            next_rdata = ptr[1][7:0];
        end else if (sfr_addr_in == OFS_PTR_B_HI) begin
            next_rdata = ptr[1][15:8];
        end else if (sfr_addr_in == OFS_PTR_A_UP) begin
            next_rdata = ptr_up[0];
        end else if (sfr_addr_in == OFS_PTR_B_UP) begin
            next_rdata = ptr_up[1];
        end else if (sfr_addr_in == OFS_IND_TOP) begin
            next_rdata = ind_top;
        end else if (sfr_addr_in == OFS_IND_MID) begin
            next_rdata = ind_mid;
        end else if (pbus.hit) begin
            next_rdata = pbus.rdata;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_out <= RST_BYTE;
            sfr_rvalid_out <= 1'b0;
        end else if (ce_in) begin
            sfr_rvalid_out <= sfr_rd_in;
            if (sfr_rd_in) begin
                sfr_rdata_out <= next_rdata;
            end
        end
    end
endmodule : xdata_sfr
`default_nettype wire

// ---- verif/xdata_sfr_assertions.sv ----
// Checker for the xdata address and port SFR block, bound to its ports.
// Assumes outputs hold while ce_in is low; port bank 0 is mirrored here.
`default_nettype none
module xdata_sfr_assertions
    import xsfr_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic clk_sys_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic ce_in, // Enable
    input wire logic sfr_wr_in, // Write
    input wire logic sfr_rd_in, // Read
    input wire logic [7:0] sfr_addr_in, // Address
    input wire logic [7:0] sfr_wdata_in, // Write data
    input wire logic [7:0] sfr_rdata_out, // Read data
    input wire logic sfr_rvalid_out, // Read valid
    input wire logic external_data_move_in, // Move
    input wire logic external_data_move_indexed_in, // Indexed move
    input wire logic [7:0] index_val_in, // Index value
    input wire logic [ADDR_W-1:0] xaddr_out, // Address out
    input wire logic xaddr_valid_out, // Address valid
    input wire logic [8*PORTS-1:0] hub_data_in, // Hub data
    input wire logic [8*PORTS-1:0] pin_out_out // Pin drive
);
    logic [7:0] sel0;
    logic [7:0] data0;
    logic [7:0] route0;
    // Own copy of bank 0, so a stuck design register cannot hide itself
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel0 <= 8'h00;
        end else if (ce_in && sfr_wr_in && sfr_addr_in == OFS_PORT_BASE + 8'h01) begin
            sel0 <= sfr_wdata_in;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data0 <= 8'h00;
        end else if (ce_in && sfr_wr_in && sfr_addr_in == OFS_PORT_BASE) begin
            data0 <= sfr_wdata_in;
        end
    end
    assign route0 = (sel0 & data0) | (~sel0 & hub_data_in[7:0]);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_move_valid: assert property (ce_in && external_data_move_in |=> xaddr_valid_out)
        else $error("no address valid after move");
    a_idle_quiet: assert property (ce_in && !external_data_move_in |=> !xaddr_valid_out)
        else $error("address valid without move");
    a_addr_holds: assert property (!xaddr_valid_out |-> $stable(xaddr_out))
        else $error("address changed without move");
    a_index_low: assert property (ce_in && external_data_move_in && external_data_move_indexed_in
        |=> xaddr_out[7:0] == $past(index_val_in)) else $error("index low byte wrong");
    a_read_valid: assert property (ce_in && sfr_rd_in |=> sfr_rvalid_out)
        else $error("no read valid");
    a_read_quiet: assert property (ce_in && !sfr_rd_in |=> !sfr_rvalid_out)
        else $error("read valid without read");
    a_rdata_holds: assert property (!sfr_rvalid_out |-> $stable(sfr_rdata_out))
        else $error("read data changed");
    a_pin_route: assert property (ce_in |=> pin_out_out[7:0] == $past(route0))
        else $error("pin drive source wrong");
endmodule : xdata_sfr_assertions
bind xdata_sfr xdata_sfr_assertions #(.PORTS(PORTS)) chk_u (.clk_sys_in, .rst_n_in, .ce_in,
    .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out, .sfr_rvalid_out,
    .external_data_move_in, .external_data_move_indexed_in, .index_val_in, .xaddr_out, .xaddr_valid_out, .hub_data_in,
    .pin_out_out);
`default_nettype wire

// ---- verif/core_model.sv ----
// Processor core model: issues pointer ops and external-data moves.
// Assumes the caller runs on the falling edge of the system clock.
`default_nettype none
module core_model
    import xsfr_pkg::*;
(
    input wire logic clk_in, // System clock
    output var ptr_op_t ptr_op_out, // Pointer op
    output logic [15:0] ptr_imm_out, // Load value
    output logic external_data_move_out, // Move strobe
    output logic indexed_out, // Move via index
    output logic [7:0] index_val_out // Index value
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ptr_op_out = PTR_HOLD;
        ptr_imm_out = 16'h0000;
        external_data_move_out = 1'b0;
        indexed_out = 1'b0;
        index_val_out = 8'h00;
    end
    task automatic issue(input ptr_op_t op, input logic [15:0] imm, input logic mv,
        input logic ix, input logic [7:0] iv);
        @(negedge clk_in);
        ptr_op_out = op;
        ptr_imm_out = imm;
        external_data_move_out = mv;
        indexed_out = ix;
        index_val_out = iv;
        @(negedge clk_in);
        ptr_op_out = PTR_HOLD;
        external_data_move_out = 1'b0;
        // Stale operands are scrambled so the design cannot lean on them
        ptr_imm_out = ~imm;
        index_val_out = ~iv;
    endtask : issue
endmodule : core_model
`default_nettype wire

// ---- verif/xdata_sfr_bench.sv ----
// Bench for the xdata address and port SFR block.
// Assumes a 25 MHz clock; inputs change on the falling edge.
`default_nettype none
module xdata_sfr_bench import xsfr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out, index_val_in;
    logic sfr_rvalid_out, external_data_move_in, external_data_move_indexed_in, xaddr_valid_out;
    ptr_op_t ptr_op_in;
    logic [15:0] ptr_imm_in, active_ptr_out;
    logic [23:0] xaddr_out;
    logic [71:0] pin_in = 72'h0;
    logic [71:0] hub_data_in = 72'h0;
    logic [71:0] pin_out_out;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    xdata_sfr dut_u (.clk_sys_in, .rst_n_in, .ce_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in,
        .sfr_wdata_in, .sfr_rdata_out, .sfr_rvalid_out, .ptr_op_in, .ptr_imm_in, .external_data_move_in,
        .external_data_move_indexed_in, .index_val_in, .active_ptr_out, .xaddr_out, .xaddr_valid_out,
        .pin_in, .hub_data_in, .pin_out_out);
    core_model core_u (.clk_in(clk_sys_in), .ptr_op_out(ptr_op_in), .ptr_imm_out(ptr_imm_in),
        .external_data_move_out(external_data_move_in), .indexed_out(external_data_move_indexed_in), .index_val_out(index_val_in));
    initial forever #20 clk_sys_in = ~clk_sys_in;
    task automatic close_out();
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // Run is about two hundred cycles; this ceiling only catches a hang
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        sfr_wr_in = 1'b1;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        @(negedge clk_sys_in);
        sfr_wr_in = 1'b0;
        sfr_wdata_in = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys_in);
        sfr_rd_in = 1'b1;
        sfr_addr_in = a;
        @(negedge clk_sys_in);
        sfr_rd_in = 1'b0;
        check("rvalid", sfr_rvalid_out, 24'h1);
        check("rdata", sfr_rdata_out, e);
    endtask : rd
    task automatic mv(input logic ix, input logic [7:0] iv, input logic [23:0] e);
        core_u.issue(PTR_HOLD, 16'h0000, 1'b1, ix, iv);
        check("xaddr_valid", xaddr_valid_out, 24'h1);
        check("xaddr", xaddr_out, e);
    endtask : mv
    task automatic reset_values();
        rd(OFS_PORT_BASE, 8'h00);
        rd(OFS_PORT_BASE + 8'h01, 8'h00);
        rd(OFS_PTR_SEL, 8'h00);
        rd(8'h01, 8'h00);
    endtask : reset_values
    task automatic pointer_moves();
        wr(OFS_PTR_A_LO, 8'h34);
        wr(OFS_PTR_A_HI, 8'h12);
        wr(OFS_PTR_A_UP, 8'h05);
        wr(OFS_PTR_B_LO, 8'hCD);
        wr(OFS_PTR_B_HI, 8'hAB);
        wr(OFS_PTR_B_UP, 8'h7E);
        wr(OFS_IND_TOP, 8'h9C);
        wr(OFS_IND_MID, 8'h3F);
        mv(1'b0, 8'h00, 24'h05_1234);
        wr(OFS_PTR_SEL, 8'h01);
        mv(1'b0, 8'h00, 24'h7E_ABCD);
        rd(OFS_PTR_SEL, 8'h01);
        mv(1'b1, 8'h5A, 24'h9C_3F5A);
        core_u.issue(PTR_INC, 16'h0000, 1'b0, 1'b0, 8'h00);
        tick(1);
        check("active_ptr", active_ptr_out, 24'h00_ABCE);
        wr(OFS_PTR_SEL, 8'h00);
        core_u.issue(PTR_LOAD, 16'h4321, 1'b0, 1'b0, 8'h00);
        tick(1);
        check("active_ptr", active_ptr_out, 24'h00_4321);
        mv(1'b0, 8'h00, 24'h05_4321);
    endtask : pointer_moves
    task automatic upper_ignored();
        wr(OFS_PTR_B_UP, 8'h11);
        wr(OFS_IND_TOP, 8'h22);
        core_u.issue(PTR_INC, 16'h0000, 1'b0, 1'b0, 8'h00);
        check("xaddr_valid", xaddr_valid_out, 24'h0);
        check("xaddr", xaddr_out, 24'h05_4321);
        wr(OFS_PTR_SEL, 8'h01);
        mv(1'b0, 8'h00, 24'h11_ABCE);
        mv(1'b1, 8'hE7, 24'h22_3FE7);
    endtask : upper_ignored
    task automatic ports_scan();
        logic [7:0] a;
        logic [7:0] s;
        logic [7:0] d;
        hub_data_in = {9{8'h96}};
        tick(2);
        check("pin_out", pin_out_out[7:0], 24'h96);
        for (int k = 0; k < NUM_PORTS; k++) begin
            a = OFS_PORT_BASE + 8'(3 * k);
            s = 8'h3C ^ 8'(k);
            d = 8'hA5 ^ 8'(k);
            wr(a + 8'h01, s);
            wr(a, d);
            tick(1);
            check("pin_out", pin_out_out[8*k+:8], (s & d) | (~s & 8'h96));
            rd(a, d);
            rd(a + 8'h01, s);
            pin_in[8*k+:8] = 8'h69 ^ 8'(k);
            wr(a + 8'h02, 8'hFF);
            rd(a + 8'h02, 8'h69 ^ 8'(k));
        end
    endtask : ports_scan
    // Clock enable low must freeze every register, a write and a move included
    task automatic ce_freeze();
        @(negedge clk_sys_in);
        ce_in = 1'b0;
        hub_data_in = {9{8'h5A}};
        sfr_wr_in = 1'b1;
        sfr_addr_in = OFS_PTR_SEL;
        sfr_wdata_in = 8'h00;
        core_u.issue(PTR_INC, 16'h0000, 1'b1, 1'b1, 8'h44);
        sfr_wr_in = 1'b0;
        ce_in = 1'b1;
        check("xaddr_valid", xaddr_valid_out, 24'h0);
        check("xaddr", xaddr_out, 24'h22_3FE7);
        check("pin_out", pin_out_out[7:0], 24'hA6);
        rd(OFS_PTR_SEL, 8'h01);
        rd(OFS_PTR_B_LO, 8'hCE);
        rd(OFS_PTR_B_UP, 8'h11);
        rd(OFS_IND_MID, 8'h3F);
        check("pin_out", pin_out_out[7:0], 24'h66);
    endtask : ce_freeze
    initial begin
        tick(2);
        rst_n_in = 1'b1;
        tick(3);
        reset_values();
        pointer_moves();
        upper_ignored();
        ports_scan();
        ce_freeze();
        close_out();
    end
endmodule : xdata_sfr_bench
`default_nettype wire
